// ===== hw/bsf_pkg.sv
/*
 * Shared constants and types of the bit, shift and flag execution unit.
 * Assumes an 8-bit core with a status register of eight flags.
 */
package bsf_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int IO_ADDR_W = 6;

    // ==========================================================
    // Status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ==========================================================
    // Reset values and cycle counts
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int IO_OP_CYCLES = 2;
    localparam int ALU_OP_CYCLES = 1;

    // ==========================================================
    // Operations
    typedef enum logic [4:0] {
        OP_SET_IO_BIT,
        OP_CLEAR_IO_BIT,
        OP_SHIFT_LEFT_LOGICAL,
        OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_SHIFT_RIGHT_ARITH,
        OP_SWAP_NIBBLES,
        OP_FLAG_SET,
        OP_FLAG_CLEAR,
        OP_BIT_TO_TRANSFER_FLAG,
        OP_TRANSFER_FLAG_TO_BIT,
        OP_CARRY_SET,
        OP_CARRY_CLEAR,
        OP_IRQ_ENABLE,
        OP_IRQ_DISABLE,
        OP_OVERFLOW_SET
    } bsf_op_t;

    typedef struct packed {
        logic valid;
        bsf_op_t op;
        logic [7:0] operand;
        logic [2:0] bitSel;
        logic [IO_ADDR_W-1:0] ioAddr;
    } bsf_cmd_t;

    typedef struct packed {
        logic we;
        logic [7:0] data;
    } bsf_reg_wr_t;

endpackage

// ===== hw/bsf_exec_unit.sv
/*
 * Execution unit for bit set/clear in I/O space, shifts, rotates,
 * nibble swap, transfer-flag moves and status flag set/clear.
 * Assumes the decoder presents one command at a time with the source
 * register value already read, and that I/O read data is returned
 * combinationally in the same cycle as the read enable.
 */
// Functional notes
// - Set I/O bit: bit forced one, 2 cycles
// - Clear I/O bit: bit forced zero, 2 cycles
// - Logical left shift, zero in, ZCNV, 1 cycle
// - Logical right shift, zero in, ZCNV, 1 cycle
// - Rotate left through carry, updates ZCNV
// - Rotate right through carry, updates ZCNV
// - Arithmetic right shift keeps sign, updates ZCNV
// - Nibble swap, no flags changed
// - Flag set writes selected status bit one
// - Flag clear writes selected status bit zero
// - Bit store copies register bit into T
// - Bit load copies T into register bit
// - Carry set and clear touch only C
// - Interrupt disable clears I flag
// - Interrupt enable sets I flag
// - Overflow set forces V, nothing else
module bsf_exec_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire bsf_pkg::bsf_cmd_t cmd,
    output logic cmdReady,
    output bsf_pkg::bsf_reg_wr_t regWr,
    output logic ioRdEn,
    output logic [bsf_pkg::IO_ADDR_W-1:0] ioAddr,
    input wire logic [7:0] ioRdData,
    output logic ioWe,
    output logic [7:0] ioWrData,
    output logic [7:0] status,
    output logic done
);

    // ==========================================================
    // State
    typedef enum logic {
        ST_IDLE,
        ST_IO_READ
    } bsf_state_t;

    bsf_state_t state;
    logic ioSetMode;
    logic [2:0] ioBit;
    logic accept;
    logic [7:0] next_result;
    logic [7:0] next_status;
    logic next_regWe;

    assign cmdReady = (state == ST_IDLE);
    assign accept = cmd.valid && cmdReady;

    // Flags common to all shifts and rotates
    function automatic logic [7:0] shiftFlags(input logic [7:0] st,
                                              input logic [7:0] res,
                                              input logic carry);
        logic [7:0] f;
        f = st;
        f[bsf_pkg::FLAG_C] = carry;
        f[bsf_pkg::FLAG_Z] = (res == 8'h00);
        f[bsf_pkg::FLAG_N] = res[7];
        f[bsf_pkg::FLAG_V] = res[7] ^ carry;
        return f;
    endfunction

    // I/O read-modify-write ops
    function automatic logic isIoOp(input bsf_pkg::bsf_op_t op);
        return (op == bsf_pkg::OP_SET_IO_BIT) || (op == bsf_pkg::OP_CLEAR_IO_BIT);
    endfunction

    // ==========================================================
    // Result and flag computation
    always_comb begin
        next_result = cmd.operand;
        next_status = status;
        next_regWe = 1'b0;
        unique case (cmd.op)
            bsf_pkg::OP_SHIFT_LEFT_LOGICAL: begin
                next_result = {cmd.operand[6:0], 1'b0};
                next_status = shiftFlags(status, next_result, cmd.operand[7]);
                next_regWe = 1'b1;
            end
            bsf_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
                next_result = {1'b0, cmd.operand[7:1]};
                next_status = shiftFlags(status, next_result, cmd.operand[0]);
                next_regWe = 1'b1;
            end
            bsf_pkg::OP_ROTATE_LEFT_CARRY: begin
                next_result = {cmd.operand[6:0], status[bsf_pkg::FLAG_C]};
                next_status = shiftFlags(status, next_result, cmd.operand[7]);
                next_regWe = 1'b1;
            end
            bsf_pkg::OP_ROTATE_RIGHT_CARRY: begin
                next_result = {status[bsf_pkg::FLAG_C], cmd.operand[7:1]};
                next_status = shiftFlags(status, next_result, cmd.operand[0]);
                next_regWe = 1'b1;
            end
            bsf_pkg::OP_SHIFT_RIGHT_ARITH: begin
                next_result = {cmd.operand[7], cmd.operand[7:1]};
                next_status = shiftFlags(status, next_result, cmd.operand[0]);
                next_regWe = 1'b1;
            end
            bsf_pkg::OP_SWAP_NIBBLES: begin
                next_result = {cmd.operand[3:0], cmd.operand[7:4]};
                next_regWe = 1'b1;
            end
            bsf_pkg::OP_FLAG_SET: begin
                next_status[cmd.bitSel] = 1'b1;
            end
            bsf_pkg::OP_FLAG_CLEAR: begin
                next_status[cmd.bitSel] = 1'b0;
            end
            bsf_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
                next_status[bsf_pkg::FLAG_T] = cmd.operand[cmd.bitSel];
            end
            bsf_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
                next_result[cmd.bitSel] = status[bsf_pkg::FLAG_T];
                next_regWe = 1'b1;
            end
            bsf_pkg::OP_CARRY_SET: begin
                next_status[bsf_pkg::FLAG_C] = 1'b1;
            end
            bsf_pkg::OP_CARRY_CLEAR: begin
                next_status[bsf_pkg::FLAG_C] = 1'b0;
            end
            bsf_pkg::OP_IRQ_ENABLE: begin
                next_status[bsf_pkg::FLAG_I] = 1'b1;
            end
            bsf_pkg::OP_IRQ_DISABLE: begin
                next_status[bsf_pkg::FLAG_I] = 1'b0;
            end
            bsf_pkg::OP_OVERFLOW_SET: begin
                next_status[bsf_pkg::FLAG_V] = 1'b1;
            end
            bsf_pkg::OP_SET_IO_BIT, bsf_pkg::OP_CLEAR_IO_BIT: begin
                next_status = status;
            end
            default: begin
                next_status = status;
            end
        endcase
    end

    // ==========================================================
    // Status register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= bsf_pkg::STATUS_RESET;
        end else if (accept) begin
            status <= next_status;
        end
    end

    // ==========================================================
    // Register file write-back
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regWr <= '0;
        end else begin
            regWr.we <= accept && next_regWe;
            if (accept && next_regWe) begin
                regWr.data <= next_result;
            end
        end
    end

    // ==========================================================
    // I/O read-modify-write sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            ioRdEn <= 1'b0;
            ioAddr <= '0;
            ioSetMode <= 1'b0;
            ioBit <= 3'h0;
            ioWe <= 1'b0;
            ioWrData <= 8'h00;
        end else begin
            ioWe <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (accept && isIoOp(cmd.op)) begin
                        state <= ST_IO_READ;
                        ioRdEn <= 1'b1;
                        ioAddr <= cmd.ioAddr;
                        ioBit <= cmd.bitSel;
                        ioSetMode <= (cmd.op == bsf_pkg::OP_SET_IO_BIT);
                    end
                end
                ST_IO_READ: begin
                    state <= ST_IDLE;
                    ioRdEn <= 1'b0;
                    ioWe <= 1'b1;
                    ioWrData <= ioRdData;
                    ioWrData[ioBit] <= ioSetMode;
                end
            endcase
        end
    end

    // ==========================================================
    // Completion pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= (accept && !isIoOp(cmd.op)) || (state == ST_IO_READ);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_io_set_bit: assert property (
        accept && cmd.op == bsf_pkg::OP_SET_IO_BIT
        |=> ioRdEn && !cmdReady ##1 ioWe && ioWrData[$past(ioBit)] && done
            && status == $past(status, 2))
        else $error("set io bit sequence wrong");

    a_io_clear_bit: assert property (
        accept && cmd.op == bsf_pkg::OP_CLEAR_IO_BIT
        |=> ##1 ioWe && !ioWrData[$past(ioBit)] && status == $past(status, 2))
        else $error("clear io bit sequence wrong");

    a_shl_result: assert property (
        accept && cmd.op == bsf_pkg::OP_SHIFT_LEFT_LOGICAL
        |=> regWr.we && regWr.data == {$past(cmd.operand[6:0]), 1'b0}
            && status[bsf_pkg::FLAG_C] == $past(cmd.operand[7]))
        else $error("left shift result wrong");

    a_shr_result: assert property (
        accept && cmd.op == bsf_pkg::OP_SHIFT_RIGHT_LOGICAL
        |=> regWr.data == {1'b0, $past(cmd.operand[7:1])}
            && !status[bsf_pkg::FLAG_N]
            && status[bsf_pkg::FLAG_V] == $past(cmd.operand[0]))
        else $error("right shift result wrong");

    a_rol_carry: assert property (
        accept && cmd.op == bsf_pkg::OP_ROTATE_LEFT_CARRY
        |=> regWr.data[0] == $past(status[bsf_pkg::FLAG_C])
            && status[bsf_pkg::FLAG_C] == $past(cmd.operand[7]))
        else $error("rotate left carry wrong");

    a_ror_carry: assert property (
        accept && cmd.op == bsf_pkg::OP_ROTATE_RIGHT_CARRY
        |=> regWr.data[7] == $past(status[bsf_pkg::FLAG_C])
            && status[bsf_pkg::FLAG_C] == $past(cmd.operand[0]))
        else $error("rotate right carry wrong");

    a_asr_sign: assert property (
        accept && cmd.op == bsf_pkg::OP_SHIFT_RIGHT_ARITH
        |=> regWr.data == {$past(cmd.operand[7]), $past(cmd.operand[7:1])}
            && status[bsf_pkg::FLAG_Z] == (regWr.data == 8'h00))
        else $error("arithmetic shift wrong");

    a_swap_flags: assert property (
        accept && cmd.op == bsf_pkg::OP_SWAP_NIBBLES
        |=> regWr.data == {$past(cmd.operand[3:0]), $past(cmd.operand[7:4])}
            && $stable(status))
        else $error("swap wrong or flags changed");

    a_flag_set_clr: assert property (
        accept && (cmd.op == bsf_pkg::OP_FLAG_SET || cmd.op == bsf_pkg::OP_FLAG_CLEAR)
        |=> status[$past(cmd.bitSel)] == ($past(cmd.op) == bsf_pkg::OP_FLAG_SET)
            && !regWr.we)
        else $error("flag set or clear wrong");

    a_bit_store: assert property (
        accept && cmd.op == bsf_pkg::OP_BIT_TO_TRANSFER_FLAG
        |=> status[bsf_pkg::FLAG_T] == $past(cmd.operand[cmd.bitSel])
            && status[5:0] == $past(status[5:0]) && status[7] == $past(status[7])
            && !regWr.we)
        else $error("bit store to transfer flag wrong");

    a_transfer_flag: assert property (
        accept && cmd.op == bsf_pkg::OP_TRANSFER_FLAG_TO_BIT
        |=> regWr.we && regWr.data[$past(cmd.bitSel)] == $past(status[bsf_pkg::FLAG_T])
            && $stable(status))
        else $error("transfer flag load wrong");

    a_irq_flag: assert property (
        accept && (cmd.op == bsf_pkg::OP_IRQ_ENABLE || cmd.op == bsf_pkg::OP_IRQ_DISABLE)
        |=> status[bsf_pkg::FLAG_I] == ($past(cmd.op) == bsf_pkg::OP_IRQ_ENABLE)
            && status[6:0] == $past(status[6:0]))
        else $error("interrupt flag wrong");

    a_carry_flag: assert property (
        accept && (cmd.op == bsf_pkg::OP_CARRY_SET || cmd.op == bsf_pkg::OP_CARRY_CLEAR)
        |=> status[bsf_pkg::FLAG_C] == ($past(cmd.op) == bsf_pkg::OP_CARRY_SET)
            && status[7:1] == $past(status[7:1]))
        else $error("carry flag op wrong");

    a_overflow_set: assert property (
        accept && cmd.op == bsf_pkg::OP_OVERFLOW_SET
        |=> status == ($past(status) | 8'h08))
        else $error("overflow set wrong");

    a_single_cycle: assert property (
        accept && cmd.op == bsf_pkg::OP_CARRY_SET |=> done && cmdReady)
        else $error("single cycle op not done next cycle");

    c_io_set: cover property (accept && cmd.op == bsf_pkg::OP_SET_IO_BIT ##2 ioWe);
    c_back_to_back: cover property (accept ##1 accept ##1 accept);
    c_rol_after_shl: cover property (
        accept && cmd.op == bsf_pkg::OP_SHIFT_LEFT_LOGICAL
        ##1 accept && cmd.op == bsf_pkg::OP_ROTATE_LEFT_CARRY);
    c_irq_toggle: cover property (
        accept && cmd.op == bsf_pkg::OP_IRQ_ENABLE
        ##1 accept && cmd.op == bsf_pkg::OP_IRQ_DISABLE);

endmodule

// ===== tb/bsf_io_space.sv
/*
 * I/O register space model facing the execution unit.
 * Assumes reads are answered combinationally while the read enable is
 * high; outside a read the data lines carry a changing pattern.
 */
module bsf_io_space (
    input wire logic clk,
    input wire logic rdEn,
    input wire logic [bsf_pkg::IO_ADDR_W-1:0] addr,
    input wire logic we,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [64];
    logic [7:0] noise = 8'h3c;

    // ==========================================================
    // Storage
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 8'(i * 37) ^ 8'h5a;
        end
    end

    always @(posedge clk) begin
        noise <= ~noise + 8'h01;
        if (we) begin
            mem[addr] <= wrData;
        end
    end

    // Not-selected reads never show stale data
    assign rdData = rdEn ? mem[addr] : noise;
endmodule

// ===== tb/testbench.sv
/*
 * Self-checking bench of the bit, shift and flag execution unit.
 * Assumes one command per cycle for single-cycle ops and two cycles
 * for I/O bit ops, with results shown that many cycles after acceptance.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic io;
        logic we;
        logic [7:0] data;
        logic [7:0] st;
        logic [5:0] addr;
        int due;
    } bsf_note_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    bsf_pkg::bsf_cmd_t cmd = '0;
    logic cmdReady, ioRdEn, ioWe, done;
    bsf_pkg::bsf_reg_wr_t regWr;
    logic [bsf_pkg::IO_ADDR_W-1:0] ioAddr;
    logic [7:0] ioRdData, ioWrData, status;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] lfsrState = 32'hda28;
    logic [7:0] expStatus = bsf_pkg::STATUS_RESET;
    logic [7:0] shadow [64];
    bsf_note_t notes [$];
    bsf_note_t head;

    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    bsf_exec_unit uut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .cmdReady(cmdReady),
        .regWr(regWr), .ioRdEn(ioRdEn), .ioAddr(ioAddr), .ioRdData(ioRdData),
        .ioWe(ioWe), .ioWrData(ioWrData), .status(status), .done(done));

    bsf_io_space ioSpace (.clk(clk), .rdEn(ioRdEn), .addr(ioAddr), .we(ioWe),
        .wrData(ioWrData), .rdData(ioRdData));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic issue(input bsf_pkg::bsf_op_t op, input logic [7:0] x,
            input logic [2:0] b, input logic [5:0] a);
        bsf_note_t n;
        logic [7:0] r;
        logic c;
        logic sh;
        int w;
        w = 0;
        sh = 1'b1;
        r = x;
        c = 1'b0;
        n = '{io: 1'b0, we: 1'b0, data: 8'h00, st: 8'h00, addr: a, due: 0};
        @(negedge clk);
        while (cmdReady !== 1'b1 && w < 10) begin
            @(negedge clk);
            w++;
        end
        if (w >= 10) begin
            num_errors++;
            $display("Error at %0t: command port stuck busy", $time);
        end
        cmd = '{valid: 1'b1, op: op, operand: x, bitSel: b, ioAddr: a};
        case (op)
            bsf_pkg::OP_SHIFT_LEFT_LOGICAL: {c, r} = {x, 1'b0};
            bsf_pkg::OP_SHIFT_RIGHT_LOGICAL: {r, c} = {1'b0, x};
            bsf_pkg::OP_ROTATE_LEFT_CARRY: {c, r} = {x, expStatus[0]};
            bsf_pkg::OP_ROTATE_RIGHT_CARRY: {r, c} = {expStatus[0], x};
            bsf_pkg::OP_SHIFT_RIGHT_ARITH: {r, c} = {x[7], x};
            default: sh = 1'b0;
        endcase
        case (op)
            bsf_pkg::OP_SET_IO_BIT: shadow[a][b] = 1'b1;
            bsf_pkg::OP_CLEAR_IO_BIT: shadow[a][b] = 1'b0;
            bsf_pkg::OP_SWAP_NIBBLES: r = {x[3:0], x[7:4]};
            bsf_pkg::OP_FLAG_SET: expStatus[b] = 1'b1;
            bsf_pkg::OP_FLAG_CLEAR: expStatus[b] = 1'b0;
            bsf_pkg::OP_BIT_TO_TRANSFER_FLAG: expStatus[bsf_pkg::FLAG_T] = x[b];
            bsf_pkg::OP_TRANSFER_FLAG_TO_BIT: r[b] = expStatus[bsf_pkg::FLAG_T];
            bsf_pkg::OP_CARRY_SET: expStatus[bsf_pkg::FLAG_C] = 1'b1;
            bsf_pkg::OP_CARRY_CLEAR: expStatus[bsf_pkg::FLAG_C] = 1'b0;
            bsf_pkg::OP_IRQ_ENABLE: expStatus[bsf_pkg::FLAG_I] = 1'b1;
            bsf_pkg::OP_IRQ_DISABLE: expStatus[bsf_pkg::FLAG_I] = 1'b0;
            bsf_pkg::OP_OVERFLOW_SET: expStatus[bsf_pkg::FLAG_V] = 1'b1;
            default: ;
        endcase
        n.io = (op == bsf_pkg::OP_SET_IO_BIT) || (op == bsf_pkg::OP_CLEAR_IO_BIT);
        n.we = sh || op == bsf_pkg::OP_SWAP_NIBBLES || op == bsf_pkg::OP_TRANSFER_FLAG_TO_BIT;
        n.data = n.io ? shadow[a] : r;
        if (sh) begin
            expStatus[bsf_pkg::FLAG_C] = c;
            expStatus[bsf_pkg::FLAG_Z] = (r == 8'h00);
            expStatus[bsf_pkg::FLAG_N] = r[7];
            expStatus[bsf_pkg::FLAG_V] = r[7] ^ c;
        end
        n.st = expStatus;
        n.due = cyc + (n.io ? bsf_pkg::IO_OP_CYCLES : bsf_pkg::ALU_OP_CYCLES);
        notes.push_back(n);
    endtask

    task automatic issueRand(input bsf_pkg::bsf_op_t op);
        lfsrState = lfsrNext(lfsrState);
        issue(op, lfsrState[15:8], lfsrState[18:16], lfsrState[24:19]);
    endtask

    task automatic conclude();
        $display("Checks: %0d, errors: %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Result watcher
    always @(negedge clk) begin
        if (rst_n && ioRdEn === 1'b1 && notes.size() > 0) begin
            checkByte({7'h0, notes[0].io}, 8'h01, "read for io op");
            checkByte({7'h0, cmdReady}, 8'h00, "busy ready");
            checkByte({2'h0, ioAddr}, {2'h0, notes[0].addr}, "read addr");
        end
        if (rst_n && done === 1'b1) begin
            if (notes.size() == 0) begin
                num_errors++;
                $display("Error at %0t: completion without a command", $time);
            end else begin
                head = notes.pop_front();
                checkByte(8'(cyc), 8'(head.due), "latency");
                checkByte(status, head.st, "status");
                checkByte({7'h0, regWr.we}, {7'h0, head.we}, "reg write");
                checkByte({7'h0, ioWe}, {7'h0, head.io}, "io write");
                if (head.we) begin
                    checkByte(regWr.data, head.data, "reg data");
                end
                if (head.io) begin
                    checkByte(ioWrData, head.data, "io data");
                    checkByte({2'h0, ioAddr}, {2'h0, head.addr}, "io addr");
                    checkByte({7'h0, ioRdEn}, 8'h00, "read end");
                end
                checkByte({7'h0, cmdReady}, 8'h01, "ready after");
            end
        end
    end

    // ==========================================================
    // Stimulus
    initial begin
        for (int i = 0; i < 64; i++) begin
            shadow[i] = 8'(i * 37) ^ 8'h5a;
        end
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        issue(bsf_pkg::OP_SHIFT_LEFT_LOGICAL, 8'h81, 3'h0, 6'h00);
        issue(bsf_pkg::OP_SET_IO_BIT, 8'h00, 3'h3, 6'h05);
        issue(bsf_pkg::OP_CLEAR_IO_BIT, 8'h00, 3'h4, 6'h05);
        for (int i = 0; i < 17; i++) begin
            issueRand(bsf_pkg::bsf_op_t'(i));
        end
        // Unlisted code: no effect, still completes
        issueRand(bsf_pkg::bsf_op_t'(5'h1f));
        for (int i = 0; i < 400; i++) begin
            issueRand(bsf_pkg::bsf_op_t'(lfsrState[4:0] % 5'd17));
        end
        @(negedge clk);
        cmd.valid = 1'b0;
        repeat (4) @(negedge clk);
        if (notes.size() != 0) begin
            num_errors++;
            $display("Error at %0t: %0d results missing", $time, notes.size());
        end
        conclude();
    end

    initial begin
        // About twice the longest run: 421 ops of at most 2 cycles
        repeat (2000) @(posedge clk);
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
